/* design/tfp_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Three-stage input synchroniser
// ----------------------------------------
module tfp_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // Capture chain
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Accept a bit once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    dout[i] <= stage3[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

/* design/tfp_main.sv */
`timescale 1ns/10ps
`default_nettype none

package tfp_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ           = 10_000_000;
    localparam int TIMEBASE_HZ      = 30;
    localparam int TIMEBASE_CYCLES  = CLK_HZ / TIMEBASE_HZ;
    localparam int STARTUP_PERIODS  = 64;

    // ----------------------------------------
    // Control level mapping, percent of supply
    // ----------------------------------------
    localparam int        LEVEL_W       = 7;
    localparam logic [6:0] PWM_MIN_PCT  = 7'h1e;
    localparam logic [6:0] PWM_MAX_PCT  = 7'h46;
    localparam int        PWM_SPAN_PCT  = 40;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic DRIVE_RST     = 1'b0;
    localparam logic DRIVE_EN_RST  = 1'b1;
    localparam logic FAULT_N_RST   = 1'b1;

    typedef enum logic [1:0] {
        ST_WAIT_START,
        ST_STARTUP,
        ST_RUN,
        ST_SLEEP
    } tfp_state_type;

    typedef struct packed {
        logic startup;
        logic overtemp;
        logic pri_below_sleep;
        logic sec_below_sleep;
        logic pri_above_wake;
        logic sec_above_wake;
        logic sleep_grounded;
    } tfp_flags_type;

endpackage

module tfp_main #(
    parameter int TB_PERIOD_CYCLES = tfp_pkg::TIMEBASE_CYCLES
) (
    input  wire logic                primary_shutdown,
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire tfp_pkg::tfp_flags_type flags_in,
    input  wire logic [6:0]          primary_temp_input,
    input  wire logic [6:0]          secondary_control_input,
    output var  logic                fan_drive,
    output var  logic                fan_drive_en_n,
    output var  logic                overtemp_fault_n
);

    localparam int HALF_CYCLES = TB_PERIOD_CYCLES / 2;

    logic                   arst_n;
    logic [1:0]             rst_pipe;
    logic                   core_rst_n;
    tfp_pkg::tfp_flags_type flags;
    tfp_pkg::tfp_state_type state;
    tfp_pkg::tfp_state_type next_state;
    logic [19:0]            phase;
    logic                   tb_tick;
    logic [6:0]             startup_count;
    logic [6:0]             level;
    logic [19:0]            tri_pos;
    logic                   pwm_raw;
    logic                   drive_pwm;
    logic                   any_wake;
    logic                   both_sleep;

    // ----------------------------------------
    // Reset and shutdown
    // ----------------------------------------
    assign arst_n = rst_n & ~primary_shutdown;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign core_rst_n = rst_pipe[1];

    tfp_sync #(
        .W ($bits(tfp_pkg::tfp_flags_type))
    ) u_flag_sync (
        .sys_clk (sys_clk),
        .rst_n   (core_rst_n),
        .din     (flags_in),
        .dout    (flags)
    );

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            phase <= 20'h00000;
        end else if (phase == 20'(TB_PERIOD_CYCLES - 1)) begin
            phase <= 20'h00000;
        end else begin
            phase <= phase + 20'h00001;
        end
    end

    assign tb_tick = (phase == 20'(TB_PERIOD_CYCLES - 1));

    // ----------------------------------------
    // Level selection and PWM compare
    // ----------------------------------------
    function automatic logic [6:0] max_level(input logic [6:0] a, input logic [6:0] b);
        max_level = (a > b) ? a : b;
    endfunction

    assign level = max_level(primary_temp_input, secondary_control_input);

    assign tri_pos = (phase < 20'(HALF_CYCLES)) ? phase
                   : 20'(TB_PERIOD_CYCLES - 1) - phase;

    always_comb begin
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = 32'(level - tfp_pkg::PWM_MIN_PCT) * 32'(HALF_CYCLES);
        rhs = 32'(tri_pos) * 32'(tfp_pkg::PWM_SPAN_PCT);
        if (level > tfp_pkg::PWM_MAX_PCT) begin
            pwm_raw = 1'b1;
        end else if (level <= tfp_pkg::PWM_MIN_PCT) begin
            pwm_raw = 1'b0;
        end else begin
            pwm_raw = (lhs > rhs);
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    assign any_wake   = flags.pri_above_wake | flags.sec_above_wake;
    assign both_sleep = flags.pri_below_sleep & flags.sec_below_sleep
                      & ~flags.sleep_grounded;

    always_comb begin
        next_state = state;
        case (state)
            tfp_pkg::ST_WAIT_START: begin
                if (flags.startup && any_wake) begin
                    next_state = tfp_pkg::ST_STARTUP;
                end else if (flags.startup) begin
                    next_state = tfp_pkg::ST_SLEEP;
                end
            end
            tfp_pkg::ST_STARTUP: begin
                if (tb_tick && startup_count == 7'(tfp_pkg::STARTUP_PERIODS - 1)) begin
                    next_state = tfp_pkg::ST_RUN;
                end
            end
            tfp_pkg::ST_RUN: begin
                if (both_sleep) begin
                    next_state = tfp_pkg::ST_SLEEP;
                end
            end
            tfp_pkg::ST_SLEEP: begin
                if (any_wake) begin
                    next_state = tfp_pkg::ST_STARTUP;
                end
            end
            default: begin
                next_state = tfp_pkg::ST_WAIT_START;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            state <= tfp_pkg::ST_WAIT_START;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            startup_count <= 7'h00;
        end else if (state != tfp_pkg::ST_STARTUP) begin
            startup_count <= 7'h00;
        end else if (tb_tick) begin
            startup_count <= startup_count + 7'h01;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign drive_pwm = (next_state == tfp_pkg::ST_STARTUP) ? 1'b1
                     : (next_state == tfp_pkg::ST_RUN) ? pwm_raw : 1'b0;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fan_drive      <= tfp_pkg::DRIVE_RST;
            fan_drive_en_n <= tfp_pkg::DRIVE_EN_RST;
        end else if (!core_rst_n) begin
            fan_drive      <= tfp_pkg::DRIVE_RST;
            fan_drive_en_n <= tfp_pkg::DRIVE_EN_RST;
        end else begin
            fan_drive      <= drive_pwm;
            fan_drive_en_n <= (next_state == tfp_pkg::ST_SLEEP)
                           || (next_state == tfp_pkg::ST_WAIT_START);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            overtemp_fault_n <= tfp_pkg::FAULT_N_RST;
        end else if (!core_rst_n) begin
            overtemp_fault_n <= tfp_pkg::FAULT_N_RST;
        end else if ((next_state == tfp_pkg::ST_RUN) || (next_state == tfp_pkg::ST_STARTUP)) begin
            overtemp_fault_n <= ~flags.overtemp;
        end else begin
            overtemp_fault_n <= 1'b1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [1:0] rise_count;
    logic       drive_prev;
    logic [6:0] level_prev;

    always_ff @(posedge sys_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            rise_count <= 2'h0;
            drive_prev <= 1'b0;
            level_prev <= 7'h00;
        end else begin
            drive_prev <= fan_drive;
            level_prev <= level;
            if (tb_tick) begin
                rise_count <= 2'h0;
            end else if (level != level_prev) begin
                rise_count <= 2'h0;
            end else if (fan_drive && !drive_prev && rise_count != 2'h3) begin
                rise_count <= rise_count + 2'h1;
            end
        end
    end

    sequence s_in_run;
        (state == tfp_pkg::ST_RUN) && (next_state == tfp_pkg::ST_RUN);
    endsequence

    sequence s_leave_startup;
        (state == tfp_pkg::ST_STARTUP) ##1 (state == tfp_pkg::ST_RUN);
    endsequence

    a_startup_len: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        s_leave_startup |-> $past(startup_count, 1) == 7'h3f)
        else $error("startup interval length wrong");

    a_startup_drive: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (next_state == tfp_pkg::ST_STARTUP) |=> fan_drive && !fan_drive_en_n)
        else $error("drive not forced during startup");

    a_level_select: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        level >= primary_temp_input && level >= secondary_control_input
        && (level == primary_temp_input || level == secondary_control_input))
        else $error("control level not the higher input");

    a_full_duty: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        s_in_run and (level > tfp_pkg::PWM_MAX_PCT) |=> fan_drive)
        else $error("drive not on above full duty level");

    a_one_pulse: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (state == tfp_pkg::ST_RUN) |-> rise_count <= 2'h1)
        else $error("more than one pulse per period");

    a_fault_set: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        s_in_run and flags.overtemp |=> !overtemp_fault_n)
        else $error("fault not asserted on overtemperature");

    a_fault_clear: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        s_in_run and !flags.overtemp |=> overtemp_fault_n)
        else $error("fault not released");

    a_sleep_enter: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (state == tfp_pkg::ST_RUN) && both_sleep |=> state == tfp_pkg::ST_SLEEP)
        else $error("sleep not entered");

    a_sleep_grounded: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (state == tfp_pkg::ST_RUN) && flags.sleep_grounded |=> state != tfp_pkg::ST_SLEEP)
        else $error("sleep entered while disabled");

    a_sleep_quiet: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (state == tfp_pkg::ST_SLEEP) && !any_wake |=> fan_drive_en_n && overtemp_fault_n
        && !fan_drive)
        else $error("outputs active in sleep");

    a_wake_exit: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (state == tfp_pkg::ST_SLEEP) && any_wake |=> state == tfp_pkg::ST_STARTUP
        ##1 fan_drive)
        else $error("wake did not start fan");

    a_wait_wake: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (state == tfp_pkg::ST_WAIT_START) && !any_wake |=> state != tfp_pkg::ST_STARTUP)
        else $error("fan started without wake");

    a_wait_quiet: assert property (@(posedge sys_clk) disable iff (!core_rst_n)
        (state == tfp_pkg::ST_WAIT_START) |-> fan_drive_en_n && overtemp_fault_n && !fan_drive)
        else $error("outputs active while waiting to start");

endmodule

`default_nettype wire

/* testbench/tfp_far_side.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Sensor dividers and comparators
// ----------------------------------------
module tfp_far_side #(
    parameter int SHUT_PCT  = 5,
    parameter int START_PCT = 8,
    parameter int OT_PCT    = 77,
    parameter int HYST_PCT  = 11
) (
    input  wire logic                   [6:0] pri_pct,
    input  wire logic                   [6:0] sec_pct,
    input  wire logic                   [6:0] slp_pct,
    output var  logic                         primary_shutdown,
    output var  tfp_pkg::tfp_flags_type       flags,
    output var  logic                   [6:0] primary_temp_input,
    output var  logic                   [6:0] secondary_control_input
);
    assign primary_shutdown        = pri_pct < SHUT_PCT;
    assign primary_temp_input      = pri_pct;
    assign secondary_control_input = sec_pct;
    assign flags.startup           = pri_pct > START_PCT;
    assign flags.overtemp          = pri_pct > OT_PCT;
    assign flags.pri_below_sleep   = pri_pct < slp_pct;
    assign flags.sec_below_sleep   = sec_pct < slp_pct;
    assign flags.pri_above_wake    = pri_pct > slp_pct + HYST_PCT;
    assign flags.sec_above_wake    = sec_pct > slp_pct + HYST_PCT;
    assign flags.sleep_grounded    = slp_pct == 7'h00;
endmodule

`default_nettype wire

/* testbench/thermal_fan_pwm_controller_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module thermal_fan_pwm_controller_bench;
    localparam int P = 200;
    logic                   sys_clk;
    logic                   rst_n;
    logic [6:0]             pri_pct;
    logic [6:0]             sec_pct;
    logic [6:0]             slp_pct;
    logic                   shut;
    tfp_pkg::tfp_flags_type flags;
    logic [6:0]             pri_lvl;
    logic [6:0]             sec_lvl;
    logic                   fan_drive;
    logic                   fan_drive_en_n;
    logic                   overtemp_fault_n;
    int                     mismatches;
    int                     compares;

    tfp_far_side far (.pri_pct(pri_pct), .sec_pct(sec_pct), .slp_pct(slp_pct),
        .primary_shutdown(shut), .flags(flags), .primary_temp_input(pri_lvl),
        .secondary_control_input(sec_lvl));

    tfp_main #(.TB_PERIOD_CYCLES(P)) DUT (.primary_shutdown(shut), .sys_clk(sys_clk),
        .rst_n(rst_n), .flags_in(flags), .primary_temp_input(pri_lvl),
        .secondary_control_input(sec_lvl), .fan_drive(fan_drive),
        .fan_drive_en_n(fan_drive_en_n), .overtemp_fault_n(overtemp_fault_n));

    // ----------------------------------------
    // Clock and checking helpers
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic set_in(input int p, input int s);
        @(negedge sys_clk);
        pri_pct = 7'(p);
        sec_pct = 7'(s);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic wait_en(input logic exp);
        int n;
        n = 0;
        while (fan_drive_en_n !== exp && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk("drive_enable_n", 16'(exp), 16'(fan_drive_en_n));
    endtask

    task automatic forced_on();
        int lows;
        lows = 0;
        chk("drive_start", 16'h0001, 16'(fan_drive));
        repeat (63 * P - 10) begin
            @(negedge sys_clk);
            if (fan_drive !== 1'b1)
                lows++;
        end
        chk("forced_lows", 16'h0000, 16'(lows));
        cyc(2 * P);
    endtask

    task automatic duty(input int lvl);
        int hi;
        int rises;
        int exp;
        logic prev;
        hi = 0;
        rises = 0;
        prev = fan_drive;
        exp = lvl <= 30 ? 0 : lvl >= 70 ? P : P * (lvl - 30) / 40;
        repeat (P) begin
            @(negedge sys_clk);
            if (fan_drive === 1'b1)
                hi++;
            if (fan_drive === 1'b1 && prev === 1'b0)
                rises++;
            prev = fan_drive;
        end
        if (hi > exp - 4 && hi < exp + 4)
            hi = exp;
        chk("duty_high", 16'(exp), 16'(hi));
        if (exp > 0 && exp < P)
            chk("pulses", 16'h0001, 16'(rises));
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_up();
        chk("reset_outputs", 16'h0003,
            {13'h0, fan_drive, fan_drive_en_n, overtemp_fault_n});
        rst_n = 1'b1;
        cyc(30);
        chk("held_shut", 16'h0003,
            {13'h0, fan_drive, fan_drive_en_n, overtemp_fault_n});
    endtask

    task automatic t_startup();
        set_in(20, 20);
        cyc(20);
        chk("no_wake_idle", 16'h0001, 16'(fan_drive_en_n));
        set_in(50, 40);
        wait_en(1'b0);
        forced_on();
    endtask

    task automatic t_duty();
        int p[5] = '{50, 40, 35, 80, 30};
        int s[5] = '{40, 60, 25, 20, 30};
        for (int i = 0; i < 5; i++) begin
            set_in(p[i], s[i]);
            cyc(P);
            duty(p[i] > s[i] ? p[i] : s[i]);
        end
    endtask

    task automatic t_overtemp();
        set_in(80, 40);
        cyc(10);
        chk("fault_on", 16'h0000, 16'(overtemp_fault_n));
        duty(80);
        set_in(60, 40);
        cyc(10);
        chk("fault_off", 16'h0001, 16'(overtemp_fault_n));
        cyc(P);
        duty(60);
    endtask

    task automatic t_sleep();
        set_in(15, 50);
        cyc(20);
        chk("one_low_runs", 16'h0000, 16'(fan_drive_en_n));
        set_in(15, 15);
        wait_en(1'b1);
        chk("sleep_out", 16'h0001, {14'h0, fan_drive, overtemp_fault_n});
        set_in(25, 15);
        cyc(20);
        chk("hyst_hold", 16'h0001, 16'(fan_drive_en_n));
        set_in(40, 15);
        wait_en(1'b0);
        forced_on();
        slp_pct = 7'h00;
        set_in(10, 10);
        cyc(20);
        chk("grounded_runs", 16'h0000, 16'(fan_drive_en_n));
    endtask

    task automatic t_shutdown();
        set_in(80, 60);
        cyc(10);
        chk("pre_shut_fault", 16'h0000, 16'(overtemp_fault_n));
        @(negedge sys_clk);
        pri_pct = 7'h02;
        #1;
        chk("shut_out", 16'h0003,
            {13'h0, fan_drive, fan_drive_en_n, overtemp_fault_n});
        cyc(20);
        set_in(6, 60);
        cyc(20);
        chk("below_start", 16'h0003,
            {13'h0, fan_drive, fan_drive_en_n, overtemp_fault_n});
        set_in(50, 60);
        wait_en(1'b0);
        chk("restart", 16'h0003, {14'h0, fan_drive, overtemp_fault_n});
    endtask

    initial begin
        #(100 * 50000);
        mismatches++;
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        pri_pct = 7'h02;
        sec_pct = 7'h00;
        slp_pct = 7'h14;
        mismatches = 0;
        compares = 0;
        cyc(10);
        t_power_up();
        t_startup();
        t_duty();
        t_overtemp();
        t_sleep();
        t_shutdown();
        test_done();
    end
endmodule

`default_nettype wire
